// ===== core/aec_pkg.sv
// Package for the addressing and exception configuration register bank
package aec_pkg;

  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned RF_BUF_DEPTH = 64;
  localparam int unsigned RF_PTR_W    = 6;
  localparam int unsigned RF_CNT_W    = 7;

  // Non-volatile copies
  localparam logic [7:0] OFS_SRC_B2_NV  = 8'h14;
  localparam logic [7:0] OFS_SRC_B1_NV  = 8'h15;
  localparam logic [7:0] OFS_SRC_B0_NV  = 8'h16;
  localparam logic [7:0] OFS_MSK_B3_NV  = 8'h17;
  localparam logic [7:0] OFS_MSK_B2_NV  = 8'h18;
  localparam logic [7:0] OFS_MSK_B1_NV  = 8'h19;
  localparam logic [7:0] OFS_MSK_B0_NV  = 8'h1a;
  localparam logic [7:0] OFS_DST_B3_NV  = 8'h1d;
  localparam logic [7:0] OFS_DST_B2_NV  = 8'h1e;
  localparam logic [7:0] OFS_DST_B1_NV  = 8'h1f;
  localparam logic [7:0] OFS_DST_B0_NV  = 8'h20;
  localparam logic [7:0] OFS_FMASK_NV   = 8'h21;
  localparam logic [7:0] OFS_HOLD_NV    = 8'h23;
  // Volatile copies, then the read-only fault code
  localparam logic [7:0] OFS_SRC_B2     = 8'h5f;
  localparam logic [7:0] OFS_SRC_B1     = 8'h60;
  localparam logic [7:0] OFS_SRC_B0     = 8'h61;
  localparam logic [7:0] OFS_MSK_B3     = 8'h62;
  localparam logic [7:0] OFS_MSK_B2     = 8'h63;
  localparam logic [7:0] OFS_MSK_B1     = 8'h64;
  localparam logic [7:0] OFS_MSK_B0     = 8'h65;
  localparam logic [7:0] OFS_DST_B3     = 8'h68;
  localparam logic [7:0] OFS_DST_B2     = 8'h69;
  localparam logic [7:0] OFS_DST_B1     = 8'h6a;
  localparam logic [7:0] OFS_DST_B0     = 8'h6b;
  localparam logic [7:0] OFS_FMASK      = 8'h6c;
  localparam logic [7:0] OFS_HOLD       = 8'h6e;
  localparam logic [7:0] OFS_FAULT_CODE = 8'h79;

  localparam logic [7:0] RST_ADDR_BYTE  = 8'hff;
  localparam logic [7:0] RST_FMASK      = 8'hff;
  localparam logic [7:0] RST_HOLD       = 8'h00;
  localparam logic [7:0] HOLD_ENABLED   = 8'h01;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;

  typedef enum logic [1:0] {
    AEC_MODE_EXT_USER = 2'h0,
    AEC_MODE_USER     = 2'h1,
    AEC_MODE_MAC      = 2'h3
  } aec_addr_mode_t;

  typedef struct packed {
    logic [7:0] src_b2;
    logic [7:0] src_b1;
    logic [7:0] src_b0;
    logic [7:0] msk_b3;
    logic [7:0] msk_b2;
    logic [7:0] msk_b1;
    logic [7:0] msk_b0;
    logic [7:0] dst_b3;
    logic [7:0] dst_b2;
    logic [7:0] dst_b1;
    logic [7:0] dst_b0;
    logic [7:0] fmask;
    logic [7:0] hold;
  } aec_cfg_t;

  localparam aec_cfg_t CFG_DEFAULT = '{
    src_b2: RST_ADDR_BYTE, src_b1: RST_ADDR_BYTE, src_b0: RST_ADDR_BYTE,
    msk_b3: RST_ADDR_BYTE, msk_b2: RST_ADDR_BYTE, msk_b1: RST_ADDR_BYTE,
    msk_b0: RST_ADDR_BYTE, dst_b3: RST_ADDR_BYTE, dst_b2: RST_ADDR_BYTE,
    dst_b1: RST_ADDR_BYTE, dst_b0: RST_ADDR_BYTE, fmask: RST_FMASK,
    hold: RST_HOLD
  };

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aec_reg_req_t;

endpackage : aec_pkg

// ===== core/aec_regs.sv
// Addressing and exception configuration register bank with RF hold buffer
`timescale 1ns/1ps
`default_nettype none

module aec_regs (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_reset,
  input  wire logic                    i_por,
  input  wire logic                    i_wake_corrupt,
  input  wire aec_pkg::aec_reg_req_t   i_reg_req,
  output logic [7:0]                   o_reg_rdata,
  output logic                         o_reg_rvalid,
  input  wire aec_pkg::aec_addr_mode_t i_addr_mode,
  input  wire logic [7:0]              i_user_source_id_b3,
  output logic [31:0]                  o_src_addr,
  output logic [31:0]                  o_addr_mask,
  output logic [31:0]                  o_dest_unique_id,
  input  wire logic                    i_fault_event,
  input  wire logic [7:0]              i_fault_code,
  output logic                         o_fault_notify_pin,
  input  wire logic                    i_cmd_line,
  input  wire logic                    i_rf_valid,
  input  wire logic [7:0]              i_rf_data,
  output logic                         o_rf_ready,
  output logic                         o_uart_valid,
  output logic [7:0]                   o_uart_data,
  input  wire logic                    i_uart_ready
);

  function automatic aec_pkg::aec_cfg_t cfg_write(
    input aec_pkg::aec_cfg_t cfg,
    input logic [7:0]        addr,
    input logic [7:0]        data,
    input logic              nv
  );
    aec_pkg::aec_cfg_t c;
    c = cfg;
    if (nv)
    begin
      unique case (addr)
        aec_pkg::OFS_SRC_B2_NV: c.src_b2 = data;
        aec_pkg::OFS_SRC_B1_NV: c.src_b1 = data;
        aec_pkg::OFS_SRC_B0_NV: c.src_b0 = data;
        aec_pkg::OFS_MSK_B3_NV: c.msk_b3 = data;
        aec_pkg::OFS_MSK_B2_NV: c.msk_b2 = data;
        aec_pkg::OFS_MSK_B1_NV: c.msk_b1 = data;
        aec_pkg::OFS_MSK_B0_NV: c.msk_b0 = data;
        aec_pkg::OFS_DST_B3_NV: c.dst_b3 = data;
        aec_pkg::OFS_DST_B2_NV: c.dst_b2 = data;
        aec_pkg::OFS_DST_B1_NV: c.dst_b1 = data;
        aec_pkg::OFS_DST_B0_NV: c.dst_b0 = data;
        aec_pkg::OFS_FMASK_NV:  c.fmask  = data;
        aec_pkg::OFS_HOLD_NV:   c.hold   = data;
        default:                c        = cfg;
      endcase
    end
    else
    begin
      unique case (addr)
        aec_pkg::OFS_SRC_B2: c.src_b2 = data;
        aec_pkg::OFS_SRC_B1: c.src_b1 = data;
        aec_pkg::OFS_SRC_B0: c.src_b0 = data;
        aec_pkg::OFS_MSK_B3: c.msk_b3 = data;
        aec_pkg::OFS_MSK_B2: c.msk_b2 = data;
        aec_pkg::OFS_MSK_B1: c.msk_b1 = data;
        aec_pkg::OFS_MSK_B0: c.msk_b0 = data;
        aec_pkg::OFS_DST_B3: c.dst_b3 = data;
        aec_pkg::OFS_DST_B2: c.dst_b2 = data;
        aec_pkg::OFS_DST_B1: c.dst_b1 = data;
        aec_pkg::OFS_DST_B0: c.dst_b0 = data;
        aec_pkg::OFS_FMASK:  c.fmask  = data;
        aec_pkg::OFS_HOLD:   c.hold   = data;
        default:             c        = cfg;
      endcase
    end
    return c;
  endfunction : cfg_write

  function automatic logic [7:0] cfg_read(
    input aec_pkg::aec_cfg_t nvc,
    input aec_pkg::aec_cfg_t vc,
    input logic [7:0]        code,
    input logic [7:0]        addr
  );
    logic [7:0] r;
    r = aec_pkg::BYTE_ZERO;
    unique case (addr)
      aec_pkg::OFS_SRC_B2_NV:  r = nvc.src_b2;
      aec_pkg::OFS_SRC_B1_NV:  r = nvc.src_b1;
      aec_pkg::OFS_SRC_B0_NV:  r = nvc.src_b0;
      aec_pkg::OFS_MSK_B3_NV:  r = nvc.msk_b3;
      aec_pkg::OFS_MSK_B2_NV:  r = nvc.msk_b2;
      aec_pkg::OFS_MSK_B1_NV:  r = nvc.msk_b1;
      aec_pkg::OFS_MSK_B0_NV:  r = nvc.msk_b0;
      aec_pkg::OFS_DST_B3_NV:  r = nvc.dst_b3;
      aec_pkg::OFS_DST_B2_NV:  r = nvc.dst_b2;
      aec_pkg::OFS_DST_B1_NV:  r = nvc.dst_b1;
      aec_pkg::OFS_DST_B0_NV:  r = nvc.dst_b0;
      aec_pkg::OFS_FMASK_NV:   r = nvc.fmask;
      aec_pkg::OFS_HOLD_NV:    r = nvc.hold;
      aec_pkg::OFS_SRC_B2:     r = vc.src_b2;
      aec_pkg::OFS_SRC_B1:     r = vc.src_b1;
      aec_pkg::OFS_SRC_B0:     r = vc.src_b0;
      aec_pkg::OFS_MSK_B3:     r = vc.msk_b3;
      aec_pkg::OFS_MSK_B2:     r = vc.msk_b2;
      aec_pkg::OFS_MSK_B1:     r = vc.msk_b1;
      aec_pkg::OFS_MSK_B0:     r = vc.msk_b0;
      aec_pkg::OFS_DST_B3:     r = vc.dst_b3;
      aec_pkg::OFS_DST_B2:     r = vc.dst_b2;
      aec_pkg::OFS_DST_B1:     r = vc.dst_b1;
      aec_pkg::OFS_DST_B0:     r = vc.dst_b0;
      aec_pkg::OFS_FMASK:      r = vc.fmask;
      aec_pkg::OFS_HOLD:       r = vc.hold;
      aec_pkg::OFS_FAULT_CODE: r = code;
      default:                 r = aec_pkg::BYTE_ZERO;
    endcase
    return r;
  endfunction : cfg_read

  aec_pkg::aec_cfg_t          nv_ff;
  aec_pkg::aec_cfg_t          vol_ff;
  aec_pkg::aec_cfg_t          nxt_nv;
  aec_pkg::aec_cfg_t          nxt_vol;
  logic [7:0]                 fault_code_ff;
  logic                       fault_pend_ff;
  logic                       nxt_fault_pend;
  logic [7:0]                 rdata_ff;
  logic                       rvalid_ff;
  logic [31:0]                src_ff;
  logic [31:0]                mask_ff;
  logic [31:0]                dest_ff;
  logic [31:0]                nxt_src;
  logic [31:0]                nxt_mask;
  logic [7:0]                 rf_mem [aec_pkg::RF_BUF_DEPTH];
  logic [aec_pkg::RF_PTR_W-1:0] wr_ptr_ff;
  logic [aec_pkg::RF_PTR_W-1:0] rd_ptr_ff;
  logic [aec_pkg::RF_CNT_W-1:0] cnt_ff;
  logic [aec_pkg::RF_CNT_W-1:0] nxt_cnt;
  logic                       rf_ready_ff;
  logic                       uart_valid_ff;
  logic [7:0]                 uart_data_ff;

  wire logic       wr_hit     = i_reg_req.wr;
  wire logic       reload     = i_reset | i_wake_corrupt;
  wire logic [7:0] masked     = vol_ff.fmask & i_fault_code;
  wire logic       fault_hit  = i_fault_event & (masked != aec_pkg::BYTE_ZERO);
  wire logic       fault_rd   = i_reg_req.rd & (i_reg_req.addr == aec_pkg::OFS_FAULT_CODE);
  wire logic       hold_on    = (vol_ff.hold == aec_pkg::HOLD_ENABLED) & ~i_cmd_line;
  wire logic       push       = i_rf_valid & rf_ready_ff;
  wire logic       buf_empty  = (cnt_ff == '0);
  wire logic       pop        = ~buf_empty & ~hold_on & (~uart_valid_ff | i_uart_ready);
  wire logic [aec_pkg::RF_CNT_W-1:0] full_cnt = aec_pkg::RF_CNT_W'(aec_pkg::RF_BUF_DEPTH);
  // Pointers wrap on their own since the depth is a power of two
  wire logic [aec_pkg::RF_PTR_W-1:0] nxt_wr_ptr = wr_ptr_ff + 1'b1;
  wire logic [aec_pkg::RF_PTR_W-1:0] nxt_rd_ptr = rd_ptr_ff + 1'b1;
  wire logic [7:0]                   rd_word    = cfg_read(nv_ff, vol_ff, fault_code_ff, i_reg_req.addr);

  // Non-volatile copy survives a plain reset; only power-on restores defaults
  always_comb
  begin
    nxt_nv = wr_hit ? cfg_write(nv_ff, i_reg_req.addr, i_reg_req.wdata, 1'b1) : nv_ff;
  end

  // Reload and power-on take priority over a write in the same cycle
  always_comb
  begin
    nxt_vol = wr_hit ? cfg_write(vol_ff, i_reg_req.addr, i_reg_req.wdata, 1'b0) : vol_ff;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_por)
      nv_ff <= aec_pkg::CFG_DEFAULT;
    else
      nv_ff <= nxt_nv;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_por)
      vol_ff <= aec_pkg::CFG_DEFAULT;
    else if (reload)
      vol_ff <= nv_ff;
    else
      vol_ff <= nxt_vol;
  end

  // Address words; user mode zeroes the unused upper half
  wire logic [31:0] ext_src   = {i_user_source_id_b3, vol_ff.src_b2, vol_ff.src_b1, vol_ff.src_b0};
  wire logic [31:0] user_src  = {16'h0000, vol_ff.src_b1, vol_ff.src_b0};
  wire logic [31:0] ext_mask  = {vol_ff.msk_b3, vol_ff.msk_b2, vol_ff.msk_b1, vol_ff.msk_b0};
  wire logic [31:0] user_mask = {16'h0000, vol_ff.msk_b1, vol_ff.msk_b0};
  wire logic [31:0] dest_word = {vol_ff.dst_b3, vol_ff.dst_b2, vol_ff.dst_b1, vol_ff.dst_b0};

  // Code 2 is no mode; it falls back to the extended form instead of leaving the words undefined
  always_comb
  begin
    unique case (i_addr_mode)
      aec_pkg::AEC_MODE_EXT_USER:
      begin
        nxt_src  = ext_src;
        nxt_mask = ext_mask;
      end
      aec_pkg::AEC_MODE_USER:
      begin
        nxt_src  = user_src;
        nxt_mask = user_mask;
      end
      aec_pkg::AEC_MODE_MAC:
      begin
        nxt_src  = ext_src;
        nxt_mask = ext_mask;
      end
      default:
      begin
        nxt_src  = ext_src;
        nxt_mask = ext_mask;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    src_ff  <= nxt_src;
    mask_ff <= nxt_mask;
    dest_ff <= dest_word;
  end

  // A new fault in the same cycle as the clearing read wins
  always_comb
  begin
    nxt_fault_pend = fault_pend_ff;
    if (fault_rd)
      nxt_fault_pend = 1'b0;
    if (fault_hit)
      nxt_fault_pend = 1'b1;
  end

  // Pending flag drives the pin straight from a flop
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      fault_pend_ff <= 1'b0;
    else
      fault_pend_ff <= nxt_fault_pend;
  end

  // Every event stores its code, masked or not
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      fault_code_ff <= aec_pkg::BYTE_ZERO;
    else if (i_fault_event)
      fault_code_ff <= i_fault_code;
  end

  // Read data answers one cycle after the request
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      rvalid_ff <= 1'b0;
    else
      rvalid_ff <= i_reg_req.rd;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      rdata_ff <= aec_pkg::BYTE_ZERO;
    else if (i_reg_req.rd)
      rdata_ff <= rd_word;
  end

  // RF buffer; when hold is off bytes flow straight through it
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (push & ~pop)
      nxt_cnt = cnt_ff + 1'b1;
    else if (pop & ~push)
      nxt_cnt = cnt_ff - 1'b1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (push)
      rf_mem[wr_ptr_ff] <= i_rf_data;
  end

  // Ready comes from the next count, so a full buffer refuses the very next byte
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      cnt_ff      <= '0;
      rf_ready_ff <= 1'b0;
    end
    else
    begin
      cnt_ff      <= nxt_cnt;
      rf_ready_ff <= (nxt_cnt != full_cnt);
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      wr_ptr_ff <= '0;
    else if (push)
      wr_ptr_ff <= nxt_wr_ptr;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      rd_ptr_ff <= '0;
    else if (pop)
      rd_ptr_ff <= nxt_rd_ptr;
  end

  // Output stage keeps the byte until the UART takes it
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      uart_valid_ff <= 1'b0;
    else if (pop)
      uart_valid_ff <= 1'b1;
    else if (i_uart_ready)
      uart_valid_ff <= 1'b0;
  end

  // Data only moves on a pop, so a stalled byte stands until taken
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      uart_data_ff <= aec_pkg::BYTE_ZERO;
    else if (pop)
      uart_data_ff <= rf_mem[rd_ptr_ff];
  end

  assign o_reg_rdata        = rdata_ff;
  assign o_reg_rvalid       = rvalid_ff;
  assign o_src_addr         = src_ff;
  assign o_addr_mask        = mask_ff;
  assign o_dest_unique_id   = dest_ff;
  assign o_fault_notify_pin = fault_pend_ff;
  assign o_rf_ready         = rf_ready_ff;
  assign o_uart_valid       = uart_valid_ff;
  assign o_uart_data        = uart_data_ff;

endmodule : aec_regs

`default_nettype wire

// ===== verification/aec_host_model.sv
// Host model: UART byte receiver and command line driver
`timescale 1ns/1ps
`default_nettype none
module aec_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_slow,
  input  wire logic       i_cmd_mode,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  output logic            o_ready,
  output logic            o_cmd_line
);
  logic [7:0] rx_q[$];
  // Command line low only while sending commands
  assign o_cmd_line = !i_cmd_mode;
  // A slow host takes a byte every other cycle so the stall path is exercised
  always @(negedge i_clk) o_ready <= i_slow ? !o_ready : 1'b1;
  always @(posedge i_clk) if (i_valid && o_ready) rx_q.push_back(i_data);
endmodule : aec_host_model
`default_nettype wire

// ===== verification/aec_regs_asserts.sv
// Concurrent checks on the configuration register bank ports
`timescale 1ns/1ps
`default_nettype none
module aec_regs_asserts (
  input wire logic                    i_clk_sys,
  input wire logic                    i_reset,
  input wire logic                    i_por,
  input wire aec_pkg::aec_reg_req_t   i_reg_req,
  input wire logic [7:0]              o_reg_rdata,
  input wire logic                    o_reg_rvalid,
  input wire aec_pkg::aec_addr_mode_t i_addr_mode,
  input wire logic [31:0]             o_src_addr,
  input wire logic [31:0]             o_addr_mask,
  input wire logic                    i_fault_event,
  input wire logic [7:0]              i_fault_code,
  input wire logic                    o_fault_notify_pin,
  input wire logic                    o_uart_valid,
  input wire logic [7:0]              o_uart_data,
  input wire logic                    i_uart_ready
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset || i_por);
  wire logic rd_code;
  assign rd_code = i_reg_req.rd && (i_reg_req.addr == aec_pkg::OFS_FAULT_CODE);
  sequence s_clear;
    rd_code && !i_fault_event;
  endsequence
  sequence s_ev_rd;
    i_fault_event ##1 s_clear;
  endsequence
  // Mode must have settled for two edges, since the output flop lags the select
  sequence s_user2;
    ($past(i_addr_mode, 2) == aec_pkg::AEC_MODE_USER) && ($past(i_addr_mode) == aec_pkg::AEC_MODE_USER);
  endsequence
  AST_SRC_USER: assert property (s_user2 |-> o_src_addr[31:16] == 16'h0000)
    else $error("user source address upper half not zero");
  AST_MASK_USER: assert property (s_user2 |-> o_addr_mask[31:16] == 16'h0000)
    else $error("user address mask upper half not zero");
  AST_PIN_CAUSE: assert property ($rose(o_fault_notify_pin) |-> $past(i_fault_event))
    else $error("fault pin rose without an event");
  AST_PIN_CLEAR: assert property (s_clear |=> !o_fault_notify_pin)
    else $error("fault pin not cleared by code read");
  AST_PIN_HOLD: assert property (o_fault_notify_pin && !rd_code |=> o_fault_notify_pin)
    else $error("fault pin dropped without a code read");
  AST_CODE_KEEP: assert property (s_ev_rd |=> o_reg_rdata == $past(i_fault_code, 2))
    else $error("fault code not stored");
  AST_RD_ANSWER: assert property (i_reg_req.rd |=> o_reg_rvalid)
    else $error("read not answered");
  AST_NO_SPUR: assert property (!i_reg_req.rd |=> !o_reg_rvalid)
    else $error("read valid without a read");
  AST_UART_HOLD: assert property (o_uart_valid && !i_uart_ready |=> o_uart_valid && $stable(o_uart_data))
    else $error("uart byte changed while stalled");
endmodule : aec_regs_asserts
bind aec_regs aec_regs_asserts chk (.i_clk_sys, .i_reset, .i_por, .i_reg_req, .o_reg_rdata, .o_reg_rvalid,
  .i_addr_mode, .o_src_addr, .o_addr_mask, .i_fault_event, .i_fault_code, .o_fault_notify_pin,
  .o_uart_valid, .o_uart_data, .i_uart_ready);
`default_nettype wire

// ===== verification/aec_regs_bench.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module aec_regs_bench;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    por = 1'b1;
  logic                    wake = 1'b0;
  aec_pkg::aec_reg_req_t   req = '0;
  aec_pkg::aec_addr_mode_t mode = aec_pkg::AEC_MODE_EXT_USER;
  logic [7:0]              b3 = 8'h00;
  logic                    fev = 1'b0;
  logic [7:0]              fcode = 8'h00;
  logic                    rfv = 1'b0;
  logic [7:0]              rfd = 8'h00;
  logic                    slow = 1'b0;
  logic                    cmd_mode = 1'b0;
  logic [7:0]              rdata;
  logic                    rvalid;
  logic [31:0]             src;
  logic [31:0]             msk;
  logic [31:0]             dst;
  logic                    pin;
  logic                    cmd;
  logic                    rfr;
  logic                    uv;
  logic [7:0]              ud;
  logic                    ur;
  logic [7:0]              v;
  logic [7:0]              m;
  logic [7:0]              c;
  logic [7:0]              vb [11];
  logic [7:0]              nvb [11];
  logic [7:0]              exp_q[$];
  int                      num_errors = 0;
  int                      check_count = 0;
  int                      seed = 1028;
  int                      i;
  int                      p;
  always #10 clk = ~clk;
  aec_regs uut (.i_clk_sys(clk), .i_reset(rst), .i_por(por), .i_wake_corrupt(wake), .i_reg_req(req),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_addr_mode(mode), .i_user_source_id_b3(b3),
    .o_src_addr(src), .o_addr_mask(msk), .o_dest_unique_id(dst), .i_fault_event(fev), .i_fault_code(fcode),
    .o_fault_notify_pin(pin), .i_cmd_line(cmd), .i_rf_valid(rfv), .i_rf_data(rfd), .o_rf_ready(rfr),
    .o_uart_valid(uv), .o_uart_data(ud), .i_uart_ready(ur));
  aec_host_model host (.i_clk(clk), .i_slow(slow), .i_cmd_mode(cmd_mode), .i_valid(uv), .i_data(ud),
    .o_ready(ur), .o_cmd_line(cmd));
  // Index order: src b2..b0, mask b3..b0, dest b3..b0, fault mask, hold
  function automatic logic [7:0] ofs(input int k, input bit nv);
    if (k < 7) return (nv ? 8'h14 : 8'h5f) + 8'(k);
    if (k < 12) return (nv ? 8'h1d : 8'h68) + 8'(k - 7);
    return nv ? 8'h23 : 8'h6e;
  endfunction : ofs
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    @(negedge clk);
  endtask : wr
  // Idle cycle after each access keeps the request from being reassigned in one step
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    d = rvalid ? rdata : 8'hxx;
    req = '0;
    @(negedge clk);
  endtask : rd
  task automatic fault_case(input logic [7:0] fm, input logic [7:0] fc);
    fev = 1'b1;
    fcode = fc;
    @(negedge clk);
    fev = 1'b0;
    chk(32'(pin), 32'(|(fm & fc)));
    rd(8'h79, v);
    chk(32'(v), 32'(fc));
    chk(32'(pin), 32'h0);
  endtask : fault_case
  task automatic push_drain(input int n, input int gap, input bit held);
    for (int k = 0; k < n; k++)
    begin
      exp_q.push_back(8'($random(seed)));
      rfv = 1'b1;
      rfd = exp_q[k];
      @(negedge clk);
      rfv = 1'b0;
      @(negedge clk);
    end
    repeat (gap) @(negedge clk);
    chk(32'(host.rx_q.size()), held ? 32'h0 : 32'(n));
    chk(32'(rfr), 32'(!held || n < aec_pkg::RF_BUF_DEPTH));
    slow = 1'b1;
    cmd_mode = 1'b0;
    for (int w = 0; w < 300 && host.rx_q.size() < n; w++) @(negedge clk);
    chk(32'(host.rx_q.size()), 32'(n));
    for (int k = 0; k < n; k++) chk(32'(host.rx_q[k]), 32'(exp_q[k]));
    host.rx_q.delete();
    exp_q.delete();
  endtask : push_drain
  initial
  begin
    repeat (8) @(negedge clk);
    por = 1'b0;
    rst = 1'b0;
    for (i = 0; i < 13; i++)
    begin
      rd(ofs(i, 1'b1), v);
      chk(32'(v), (i == 12) ? 32'h0 : 32'hff);
      rd(ofs(i, 1'b0), v);
      chk(32'(v), (i == 12) ? 32'h0 : 32'hff);
    end
    rd(8'h00, v);
    chk(32'(v), 32'h0);
    fault_case(8'hff, 8'h80);
    for (i = 0; i < 11; i++)
    begin
      vb[i] = 8'($random(seed));
      nvb[i] = 8'($random(seed));
      wr(ofs(i, 1'b0), vb[i]);
      wr(ofs(i, 1'b1), nvb[i]);
    end
    b3 = 8'($random(seed));
    repeat (4) @(negedge clk);
    chk(src, {b3, vb[0], vb[1], vb[2]});
    chk(msk, {vb[3], vb[4], vb[5], vb[6]});
    chk(dst, {vb[7], vb[8], vb[9], vb[10]});
    mode = aec_pkg::AEC_MODE_USER;
    repeat (4) @(negedge clk);
    chk(src, {16'h0000, vb[1], vb[2]});
    chk(msk, {16'h0000, vb[5], vb[6]});
    mode = aec_pkg::AEC_MODE_MAC;
    for (p = 0; p < 2; p++)
    begin
      for (i = 0; i < 11; i++) wr(ofs(i, 1'b0), ~nvb[i]);
      wake = (p == 0);
      rst = (p == 1);
      @(negedge clk);
      wake = 1'b0;
      rst = 1'b0;
      for (i = 0; i < 11; i++)
      begin
        rd(ofs(i, 1'b0), v);
        chk(32'(v), 32'(nvb[i]));
      end
    end
    for (i = 0; i < 8; i++)
    begin
      m = 8'($random(seed)) | (8'h01 << i);
      c = i[0] ? (8'($random(seed)) & ~m) : (8'($random(seed)) | (8'h01 << i));
      wr(8'h6c, m);
      fault_case(m, c);
    end
    wr(8'h6e, 8'h01);
    cmd_mode = 1'b1;
    push_drain(5, 10, 1'b1);
    cmd_mode = 1'b1;
    push_drain(64, 10, 1'b1);
    wr(8'h6e, 8'h00);
    cmd_mode = 1'b1;
    push_drain(3, 10, 1'b0);
    close_out();
  end
  // Whole run needs about six hundred cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule : aec_regs_bench
`default_nettype wire
